/* File: design/dtcu_top.sv */
// Dual timer/counter unit with external interrupt 0/1 flag logic.
// Assumes a byte-wide register port on clk_sys and vector pulses from the CPU.
`timescale 1ns/1ns
module dtcu_top (
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata_q,
  input  wire logic       vector_ack_timer0,
  input  wire logic       vector_ack_timer1,
  input  wire logic       vector_ack_ext0,
  input  wire logic       vector_ack_ext1,
  input  wire logic       idle_request,
  input  wire logic       power_down_request,
  input  wire logic       ext_irq_pin_zero,
  input  wire logic       ext_irq_pin_one,
  input  wire logic       count_pin_zero,
  input  wire logic       count_pin_one,
  input  wire logic       sub_oscillator_clock,
  output logic            timer0_overflow_flag,
  output logic            timer1_overflow_flag,
  output logic            ext_irq0_flag,
  output logic            ext_irq1_flag,
  output logic            system_clock_select
);
  import dtcu_pkg::*;

  logic [4:0]  pin_meta_q;
  logic [4:0]  pin_sync_q;
  logic [4:0]  pin_prev_q;
  logic [4:0]  pin_fall;
  logic        sub_rise;

  logic [1:0]  tf_q;
  logic [1:0]  tr_q;
  logic [1:0]  ie_q;
  logic [1:0]  it_q;
  logic [7:0]  mode_q;
  logic [7:0]  clksel_q;
  logic [9:0]  pre_q;

  logic        wr_control;
  logic [1:0]  ack_timer;
  logic [1:0]  ack_ext;
  logic [1:0]  gate_ok;
  logic [1:0]  pre_tick;
  logic [1:0]  tick;
  logic [1:0]  ovf;
  logic [1:0]  wr_low;
  logic [1:0]  wr_high;
  logic [7:0]  cnt_low [2];
  logic [7:0]  cnt_high [2];

  assign wr_control = sfr_wr && (sfr_addr == DTCU_ADDR_CONTROL);
  assign ack_timer  = {vector_ack_timer1, vector_ack_timer0};
  assign ack_ext    = {vector_ack_ext1, vector_ack_ext0};

  // Two-stage synchronisers for every pin; edges taken past the second stage
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      pin_meta_q <= DTCU_PIN_IDLE;
      pin_sync_q <= DTCU_PIN_IDLE;
      pin_prev_q <= DTCU_PIN_IDLE;
    end
    else
    begin
      pin_meta_q <= {sub_oscillator_clock, count_pin_one, count_pin_zero,
                     ext_irq_pin_one, ext_irq_pin_zero};
      pin_sync_q <= pin_meta_q;
      pin_prev_q <= pin_sync_q;
    end
  end

  assign pin_fall = pin_prev_q & ~pin_sync_q;
  assign sub_rise = pin_sync_q[DTCU_PIN_SUB] & ~pin_prev_q[DTCU_PIN_SUB];

  // Shared prescaler; frozen in power-down, free in idle
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      pre_q <= '0;
    else if (!power_down_request)
      pre_q <= pre_q + DTCU_PRE_ONE;
  end

  // Mode and clock select registers
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      mode_q   <= DTCU_RST_BYTE;
      clksel_q <= DTCU_RST_BYTE;
    end
    else if (sfr_wr)
    begin
      if (sfr_addr == DTCU_ADDR_MODE)
        mode_q <= sfr_wdata;
      if (sfr_addr == DTCU_ADDR_CLKSEL)
        clksel_q <= sfr_wdata;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      system_clock_select <= 1'b0;
    else
      system_clock_select <= clksel_q[DTCU_CK_SYSSEL];
  end

  for (genvar i = 0; i < 2; i++)
  begin : g_timer
    dtcu_mode_t mode_i;
    dtcu_src_t  src_i;

    assign mode_i = dtcu_mode_t'(mode_q[DTCU_MODE_NIB*i+DTCU_MODE_LSB +: 2]);
    assign src_i  = dtcu_src_t'(clksel_q[DTCU_CK_SRC0+DTCU_CK_STEP*i +: 2]);

    always_comb
    begin
      case (src_i)
        DTCU_SRC_DIV4:    pre_tick[i] = ((pre_q & DTCU_PRE_MASK4) == DTCU_PRE_MASK4);
        DTCU_SRC_DIV64:   pre_tick[i] = ((pre_q & DTCU_PRE_MASK64) == DTCU_PRE_MASK64);
        DTCU_SRC_DIV1024: pre_tick[i] = ((pre_q & DTCU_PRE_MASK1K) == DTCU_PRE_MASK1K);
        default:          pre_tick[i] = sub_rise;
      endcase
    end

    // Gate requires the interrupt pin high; without gate only run and power-down matter
    assign gate_ok[i] = !mode_q[DTCU_MODE_NIB*i+DTCU_MODE_GATE]
                        || pin_sync_q[DTCU_PIN_EXT_IRQ_PIN_ZERO+i];
    assign tick[i] = tr_q[i] && gate_ok[i] && !power_down_request
                     && (mode_q[DTCU_MODE_NIB*i+DTCU_MODE_CT]
                         ? pin_fall[DTCU_PIN_CNT0+i] : pre_tick[i]);

    dtcu_timer u_timer (
      .clk_sys    (clk_sys),
      .reset      (reset),
      .tick       (tick[i]),
      .mode       (mode_i),
      .wr_low     (wr_low[i]),
      .wr_high    (wr_high[i]),
      .wdata      (sfr_wdata),
      .count_low  (cnt_low[i]),
      .count_high (cnt_high[i]),
      .overflow   (ovf[i])
    );

    // Overflow flag: set wins over software write and vector clear
    always_ff @(posedge clk_sys)
    begin
      if (reset)
        tf_q[i] <= 1'b0;
      else if (ovf[i])
        tf_q[i] <= 1'b1;
      else if (wr_control)
        tf_q[i] <= sfr_wdata[DTCU_CTL_TF0+DTCU_CTL_STEP*i];
      else if (ack_timer[i])
        tf_q[i] <= 1'b0;
    end

    always_ff @(posedge clk_sys)
    begin
      if (reset)
      begin
        tr_q[i] <= 1'b0;
        it_q[i] <= 1'b0;
      end
      else if (wr_control)
      begin
        tr_q[i] <= sfr_wdata[DTCU_CTL_TR0+DTCU_CTL_STEP*i];
        it_q[i] <= sfr_wdata[DTCU_CTL_IT0+DTCU_CTL_STEP*i];
      end
    end

    // External flag: latched on falling edge, or tracking a low pin level
    always_ff @(posedge clk_sys)
    begin
      if (reset)
        ie_q[i] <= 1'b0;
      else if (!it_q[i])
        ie_q[i] <= !pin_sync_q[DTCU_PIN_EXT_IRQ_PIN_ZERO+i];
      else if (pin_fall[DTCU_PIN_EXT_IRQ_PIN_ZERO+i])
        ie_q[i] <= 1'b1;
      else if (wr_control)
        ie_q[i] <= sfr_wdata[DTCU_CTL_IE0+DTCU_CTL_STEP*i];
      else if (ack_ext[i])
        ie_q[i] <= 1'b0;
    end
  end

  assign wr_low[0]  = sfr_wr && (sfr_addr == DTCU_ADDR_T0_LOW);
  assign wr_high[0] = sfr_wr && (sfr_addr == DTCU_ADDR_T0_HIGH);
  assign wr_low[1]  = sfr_wr && (sfr_addr == DTCU_ADDR_T1_LOW);
  assign wr_high[1] = sfr_wr && (sfr_addr == DTCU_ADDR_T1_HIGH);

  assign timer0_overflow_flag = tf_q[0];
  assign timer1_overflow_flag = tf_q[1];
  assign ext_irq0_flag        = ie_q[0];
  assign ext_irq1_flag        = ie_q[1];

  // Read data registered one cycle after the address; unmapped reads zero
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      sfr_rdata_q <= DTCU_RST_BYTE;
    else
    begin
      case (sfr_addr)
        DTCU_ADDR_CONTROL: sfr_rdata_q <= {tf_q[1], tr_q[1], tf_q[0], tr_q[0],
                                           ie_q[1], it_q[1], ie_q[0], it_q[0]};
        DTCU_ADDR_MODE:    sfr_rdata_q <= mode_q;
        DTCU_ADDR_T0_LOW:  sfr_rdata_q <= cnt_low[0];
        DTCU_ADDR_T0_HIGH: sfr_rdata_q <= cnt_high[0];
        DTCU_ADDR_T1_LOW:  sfr_rdata_q <= cnt_low[1];
        DTCU_ADDR_T1_HIGH: sfr_rdata_q <= cnt_high[1];
        DTCU_ADDR_CLKSEL:  sfr_rdata_q <= clksel_q;
        default:           sfr_rdata_q <= DTCU_RST_BYTE;
      endcase
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence s_t0_quiet;
    !wr_low[0] && !wr_high[0];
  endsequence

  sequence s_t0_reload_ovf;
    s_t0_quiet and (ovf[0] && mode_q[1:0] == DTCU_MODE_RELOAD);
  endsequence

  a_tf_set_overflow: assert property (
    ovf[1] |=> timer1_overflow_flag ##1 timer1_overflow_flag || !wr_control)
    else $error("timer 1 overflow did not set its flag");

  a_tf_vector_clear: assert property (
    (vector_ack_timer0 && !ovf[0] && !wr_control) |=> !timer0_overflow_flag)
    else $error("timer 0 vector did not clear the overflow flag");

  a_run_holds_count: assert property (
    (s_t0_quiet and !tr_q[0]) |=> $stable(cnt_low[0]) && $stable(cnt_high[0]))
    else $error("timer 0 counted with run bit clear");

  a_ext_edge_set: assert property (
    (it_q[0] && pin_fall[DTCU_PIN_EXT_IRQ_PIN_ZERO]) |=> ext_irq0_flag)
    else $error("falling edge did not set external flag 0");

  a_ext_edge_ack: assert property (
    (it_q[1] && vector_ack_ext1 && !pin_fall[DTCU_PIN_EXT_IRQ_PIN_ZERO+1] && !wr_control)
    |=> !ext_irq1_flag)
    else $error("edge flag 1 not cleared on vector");

  a_ext_level_track: assert property (
    (!it_q[0] && !wr_control) |=> ext_irq0_flag == !$past(pin_sync_q[DTCU_PIN_EXT_IRQ_PIN_ZERO]))
    else $error("level flag 0 did not follow the pin");

  a_gate_blocks_tick: assert property (
    (mode_q[DTCU_MODE_GATE] && !pin_sync_q[DTCU_PIN_EXT_IRQ_PIN_ZERO]) |-> !tick[0])
    else $error("gated timer 0 counted while pin low");

  a_reload_from_high: assert property (
    s_t0_reload_ovf |=> cnt_low[0] == $past(cnt_high[0]))
    else $error("reload mode did not copy high byte");

  a_powerdown_freeze: assert property (
    power_down_request |-> !tick[0] && !tick[1] ##1 !power_down_request || !tick[0])
    else $error("timer ticked in power-down");

  a_div4_rate: assert property (
    disable iff (reset || power_down_request)
    (clksel_q[3:2] == DTCU_SRC_DIV4 && pre_tick[0]) |=> !pre_tick[0] [*3])
    else $error("divide-by-4 tick spacing wrong");

  a_idle_keeps_prescale: assert property (
    (idle_request && !power_down_request) |=> pre_q == $past(pre_q) + DTCU_PRE_ONE)
    else $error("prescaler stopped in idle mode");

endmodule

/* File: design/dtcu_pkg.sv */
// Constants shared by the dual timer/counter unit and its timer core.
// Assumes one system clock and an 8-bit special function register port.
package dtcu_pkg;

  // Register addresses in the special function register space
  localparam logic [7:0] DTCU_ADDR_CONTROL = 8'h88;
  localparam logic [7:0] DTCU_ADDR_MODE    = 8'h89;
  localparam logic [7:0] DTCU_ADDR_T0_LOW  = 8'h8A;
  localparam logic [7:0] DTCU_ADDR_T1_LOW  = 8'h8B;
  localparam logic [7:0] DTCU_ADDR_T0_HIGH = 8'h8C;
  localparam logic [7:0] DTCU_ADDR_T1_HIGH = 8'h8D;
  localparam logic [7:0] DTCU_ADDR_CLKSEL  = 8'h8E;

  // Reset values
  localparam logic [7:0] DTCU_RST_BYTE = 8'h00;
  localparam logic [1:0] DTCU_RST_PAIR = 2'h0;

  // Timer control bit positions for timer 0; timer 1 sits one step higher
  localparam int DTCU_CTL_IT0  = 0;
  localparam int DTCU_CTL_IE0  = 1;
  localparam int DTCU_CTL_TR0  = 4;
  localparam int DTCU_CTL_TF0  = 5;
  localparam int DTCU_CTL_STEP = 2;

  // Timer mode nibble: timer 0 low nibble, timer 1 high nibble
  localparam int DTCU_MODE_NIB  = 4;
  localparam int DTCU_MODE_GATE = 3;
  localparam int DTCU_MODE_CT   = 2;
  localparam int DTCU_MODE_LSB  = 0;

  // Clock select one fields
  localparam int DTCU_CK_SYSSEL = 0;
  localparam int DTCU_CK_SRC0   = 2;
  localparam int DTCU_CK_STEP   = 2;

  typedef enum logic [1:0] {
    DTCU_MODE_13     = 2'h0,
    DTCU_MODE_16     = 2'h1,
    DTCU_MODE_RELOAD = 2'h2,
    DTCU_MODE_RSVD   = 2'h3
  } dtcu_mode_t;

  typedef enum logic [1:0] {
    DTCU_SRC_DIV4    = 2'h0,
    DTCU_SRC_DIV64   = 2'h1,
    DTCU_SRC_DIV1024 = 2'h2,
    DTCU_SRC_SUBOSC  = 2'h3
  } dtcu_src_t;

  // Prescaler: a tick when the masked bits are all ones
  localparam int          DTCU_PRE_W       = 10;
  localparam logic [9:0]  DTCU_PRE_ONE     = 10'h001;
  localparam logic [9:0]  DTCU_PRE_MASK4   = 10'h003;
  localparam logic [9:0]  DTCU_PRE_MASK64  = 10'h03F;
  localparam logic [9:0]  DTCU_PRE_MASK1K  = 10'h3FF;

  // Counting constants
  localparam logic [7:0]  DTCU_BYTE_ONE    = 8'h01;
  localparam logic [7:0]  DTCU_BYTE_FULL   = 8'hFF;
  localparam logic [4:0]  DTCU_LOW13_FULL  = 5'h1F;
  localparam logic [4:0]  DTCU_LOW13_ONE   = 5'h01;
  localparam logic [15:0] DTCU_WORD_ONE    = 16'h0001;
  localparam logic [15:0] DTCU_WORD_FULL   = 16'hFFFF;

  // Pin synchroniser lanes
  localparam int         DTCU_PIN_EXT_IRQ_PIN_ZERO = 0;
  localparam int         DTCU_PIN_CNT0 = 2;
  localparam int         DTCU_PIN_SUB  = 4;
  localparam int         DTCU_PIN_N    = 5;
  localparam logic [4:0] DTCU_PIN_IDLE = 5'h1F;

endpackage

/* File: design/dtcu_timer.sv */
// One timer/counter core: low and high count bytes and the four modes.
// Assumes the caller supplies a single-cycle count tick and byte writes.
`timescale 1ns/1ns
module dtcu_timer (
  input  wire logic              clk_sys,
  input  wire logic              reset,
  input  wire logic              tick,
  input  wire dtcu_pkg::dtcu_mode_t mode,
  input  wire logic              wr_low,
  input  wire logic              wr_high,
  input  wire logic [7:0]        wdata,
  output logic      [7:0]        count_low,
  output logic      [7:0]        count_high,
  output logic                   overflow
);
  import dtcu_pkg::*;

  logic [7:0]  low_d;
  logic [7:0]  high_d;
  logic [15:0] word_inc;

  assign word_inc = {count_high, count_low} + DTCU_WORD_ONE;

  // A byte write in the same cycle takes precedence over counting
  always_comb
  begin
    low_d    = count_low;
    high_d   = count_high;
    overflow = 1'b0;
    if (tick && !wr_low && !wr_high)
    begin
      case (mode)
        DTCU_MODE_13:
        begin
          low_d[4:0] = count_low[4:0] + DTCU_LOW13_ONE;
          if (count_low[4:0] == DTCU_LOW13_FULL)
          begin
            high_d   = count_high + DTCU_BYTE_ONE;
            overflow = (count_high == DTCU_BYTE_FULL);
          end
        end
        DTCU_MODE_16:
        begin
          {high_d, low_d} = word_inc;
          overflow = ({count_high, count_low} == DTCU_WORD_FULL);
        end
        DTCU_MODE_RELOAD:
        begin
          overflow = (count_low == DTCU_BYTE_FULL);
          low_d    = overflow ? count_high : count_low + DTCU_BYTE_ONE;
        end
        default:
        begin
          low_d = count_low; // Reserved mode holds the count
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      count_low  <= DTCU_RST_BYTE;
      count_high <= DTCU_RST_BYTE;
    end
    else
    begin
      count_low  <= wr_low ? wdata : low_d;
      count_high <= wr_high ? wdata : high_d;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  a_carry_into_high: assert property (
    (tick && !wr_low && !wr_high && mode == DTCU_MODE_13
      && count_low[4:0] == DTCU_LOW13_FULL)
    |=> count_high == $past(count_high) + DTCU_BYTE_ONE)
    else $error("13-bit carry did not reach the high byte");

endmodule

/* File: bench/dtcu_pins.sv */
// Pin-side model: interrupt pins, count pins and a free-running sub-oscillator.
// Assumes the bench calls its tasks; pins move 1 ns after a rising clk_sys.
`timescale 1ns/1ns
module dtcu_pins (
  input  wire logic clk_sys,
  output logic      ext_irq_pin_zero,
  output logic      ext_irq_pin_one,
  output logic      count_pin_zero,
  output logic      count_pin_one,
  output logic      sub_oscillator_clock
);
  initial
  begin
    ext_irq_pin_zero     = 1'b1;
    ext_irq_pin_one      = 1'b1;
    count_pin_zero       = 1'b1;
    count_pin_one        = 1'b1;
    sub_oscillator_clock = 1'b0;
    #3;
    forever #40 sub_oscillator_clock = ~sub_oscillator_clock;
  end

  task automatic set_irq(input int idx, input logic v);
    @(posedge clk_sys);
    #1;
    if (idx == 0)
      ext_irq_pin_zero = v;
    else
      ext_irq_pin_one = v;
  endtask

  task automatic set_cnt(input int idx, input logic v);
    if (idx == 0)
      count_pin_zero = v;
    else
      count_pin_one = v;
  endtask

  // Each low level lasts four cycles and each high level at least four, so the two-stage synchroniser sees it
  task automatic pulse_count(input int idx, input int n);
    repeat (n)
    begin
      @(posedge clk_sys);
      #1;
      set_cnt(idx, 1'b0);
      repeat (4) @(posedge clk_sys);
      #1;
      set_cnt(idx, 1'b1);
      repeat (4) @(posedge clk_sys);
    end
    #1;
  endtask
endmodule

/* File: bench/dtcu_top_tb.sv */
// Self-checking bench for the dual timer/counter unit.
// Assumes dtcu_pins drives the pins; the bench owns the register port.
`timescale 1ns/1ns
module dtcu_top_tb;
  logic       clk_sys;
  logic       reset;
  logic [7:0] sfr_addr;
  logic       sfr_wr;
  logic [7:0] sfr_wdata;
  logic [7:0] sfr_rdata_q;
  logic [3:0] vack;
  logic       idle_request;
  logic       power_down_request;
  logic       p_i0;
  logic       p_i1;
  logic       p_c0;
  logic       p_c1;
  logic       p_sub;
  logic [1:0] tf;
  logic [1:0] ef;
  logic       system_clock_select;
  int         miscompares;
  int         n_tests;
  int         cycles;

  dtcu_top DUT (
    .clk_sys              (clk_sys),
    .reset                (reset),
    .sfr_addr             (sfr_addr),
    .sfr_wr               (sfr_wr),
    .sfr_wdata            (sfr_wdata),
    .sfr_rdata_q          (sfr_rdata_q),
    .vector_ack_timer0    (vack[0]),
    .vector_ack_timer1    (vack[1]),
    .vector_ack_ext0      (vack[2]),
    .vector_ack_ext1      (vack[3]),
    .idle_request         (idle_request),
    .power_down_request   (power_down_request),
    .ext_irq_pin_zero     (p_i0),
    .ext_irq_pin_one      (p_i1),
    .count_pin_zero       (p_c0),
    .count_pin_one        (p_c1),
    .sub_oscillator_clock (p_sub),
    .timer0_overflow_flag (tf[0]),
    .timer1_overflow_flag (tf[1]),
    .ext_irq0_flag        (ef[0]),
    .ext_irq1_flag        (ef[1]),
    .system_clock_select  (system_clock_select)
  );

  dtcu_pins pins (
    .clk_sys              (clk_sys),
    .ext_irq_pin_zero     (p_i0),
    .ext_irq_pin_one      (p_i1),
    .count_pin_zero       (p_c0),
    .count_pin_one        (p_c1),
    .sub_oscillator_clock (p_sub)
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      miscompares++;
      tally_and_finish;
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1;
    sfr_addr  = a;
    sfr_wr    = 1'b1;
    sfr_wdata = d;
    @(posedge clk_sys);
    #1;
    sfr_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    #1;
    sfr_addr = a;
    @(posedge clk_sys);
    #1;
    d = sfr_rdata_q;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk({8'h00, d}, {8'h00, e});
  endtask

  task automatic vpulse(input int i);
    @(posedge clk_sys);
    #1;
    vack[i] = 1'b1;
    @(posedge clk_sys);
    #1;
    vack[i] = 1'b0;
  endtask

  task automatic arm(input logic [7:0] md, input logic [7:0] lo, input logic [7:0] hi);
    wr(8'h89, md);
    wr(8'h8A, lo);
    wr(8'h8C, hi);
    wr(8'h88, 8'h10);
  endtask

  task automatic t_reset;
    for (logic [7:0] a = 8'h88; a <= 8'h8E; a++)
      rchk(a, 8'h00);
    rchk(8'h90, 8'h00);
    $display("test reset values done");
  endtask

  task automatic t_regs;
    wr(8'h8A, 8'h5A);
    wr(8'h8C, 8'hA5);
    wr(8'h8B, 8'h3C);
    wr(8'h8D, 8'hC3);
    wr(8'h89, 8'h96);
    wr(8'h90, 8'hFF);
    rchk(8'h8A, 8'h5A);
    rchk(8'h8C, 8'hA5);
    rchk(8'h8B, 8'h3C);
    rchk(8'h8D, 8'hC3);
    rchk(8'h89, 8'h96);
    rchk(8'h90, 8'h00);
    wr(8'h8E, 8'h01);
    cyc(2);
    chk({15'h0, system_clock_select}, 16'h1);
    wr(8'h8E, 8'h00);
    cyc(2);
    chk({15'h0, system_clock_select}, 16'h0);
    $display("test register access done");
  endtask

  task automatic t_modes;
    pins.set_irq(0, 1'b0);
    arm(8'h04, 8'hFF, 8'h00);
    pins.pulse_count(0, 1);
    rchk(8'h8A, 8'hE0);
    rchk(8'h8C, 8'h01);
    pins.set_irq(0, 1'b1);
    arm(8'h05, 8'hFF, 8'hFF);
    pins.pulse_count(0, 1);
    rchk(8'h8A, 8'h00);
    rchk(8'h8C, 8'h00);
    chk({15'h0, tf[0]}, 16'h1);
    vpulse(0);
    chk({15'h0, tf[0]}, 16'h0);
    wr(8'h88, 8'h20);
    rchk(8'h88, 8'h20);
    pins.pulse_count(0, 2);
    rchk(8'h8A, 8'h00);
    arm(8'h06, 8'hFF, 8'h80);
    pins.pulse_count(0, 1);
    rchk(8'h8A, 8'h80);
    chk({15'h0, tf[0]}, 16'h1);
    wr(8'h89, 8'h50);
    wr(8'h8B, 8'hFF);
    wr(8'h8D, 8'hFF);
    wr(8'h88, 8'h40);
    pins.pulse_count(1, 3);
    rchk(8'h8B, 8'h02);
    chk({14'h0, tf}, 16'h2);
    vpulse(1);
    chk({15'h0, tf[1]}, 16'h0);
    arm(8'h07, 8'h12, 8'h34);
    pins.pulse_count(0, 2);
    rchk(8'h8A, 8'h12);
    rchk(8'h8C, 8'h34);
    $display("test count modes done");
  endtask

  task automatic t_gate_power;
    arm(8'h0D, 8'h00, 8'h00);
    pins.set_irq(0, 1'b0);
    pins.pulse_count(0, 2);
    rchk(8'h8A, 8'h00);
    pins.set_irq(0, 1'b1);
    pins.pulse_count(0, 2);
    rchk(8'h8A, 8'h02);
    arm(8'h05, 8'h00, 8'h00);
    power_down_request = 1'b1;
    pins.pulse_count(0, 2);
    rchk(8'h8A, 8'h00);
    power_down_request = 1'b0;
    idle_request = 1'b1;
    pins.pulse_count(0, 2);
    rchk(8'h8A, 8'h02);
    idle_request = 1'b0;
    $display("test gating and power done");
  endtask

  task automatic t_ext;
    for (int i = 0; i < 2; i++)
    begin
      wr(8'h88, i ? 8'h04 : 8'h01);
      pins.set_irq(i, 1'b0);
      cyc(5);
      chk({15'h0, ef[i]}, 16'h1);
      pins.set_irq(i, 1'b1);
      cyc(5);
      chk({15'h0, ef[i]}, 16'h1);
      vpulse(2 + i);
      chk({15'h0, ef[i]}, 16'h0);
      wr(8'h88, 8'h00);
      pins.set_irq(i, 1'b0);
      cyc(5);
      chk({15'h0, ef[i]}, 16'h1);
      vpulse(2 + i);
      chk({15'h0, ef[i]}, 16'h1);
      pins.set_irq(i, 1'b1);
      cyc(5);
      chk({15'h0, ef[i]}, 16'h0);
    end
    $display("test external flags done");
  endtask

  task automatic t_prescale;
    int         win [4] = '{64, 1024, 4096, 320};
    int         exp [4] = '{16, 16, 4, 16};
    logic [7:0] l;
    logic [7:0] h;
    for (int t = 0; t < 2; t++)
      for (int s = 0; s < 4; s++)
      begin
        wr(8'h89, t ? 8'h10 : 8'h01);
        wr(8'h8E, 8'(s << (2 + 2 * t)));
        wr(8'h8A + 8'(t), 8'h00);
        wr(8'h8C + 8'(t), 8'h00);
        wr(8'h88, t ? 8'h40 : 8'h10);
        cyc(win[s]);
        wr(8'h88, 8'h00);
        rd(8'h8A + 8'(t), l);
        rd(8'h8C + 8'(t), h);
        chk({15'h0, {h, l} >= 16'(exp[s] - 1) && {h, l} <= 16'(exp[s] + 1)}, 16'h1);
      end
    $display("test clock sources done");
  endtask

  initial
  begin
    miscompares        = 0;
    n_tests            = 0;
    cycles             = 0;
    sfr_addr           = 8'h00;
    sfr_wr             = 1'b0;
    sfr_wdata          = 8'h00;
    vack               = 4'h0;
    idle_request       = 1'b0;
    power_down_request = 1'b0;
    reset              = 1'b1;
    repeat (20) @(posedge clk_sys);
    #1;
    reset = 1'b0;
    cyc(3);
    t_reset;
    t_regs;
    t_modes;
    t_gate_power;
    t_ext;
    t_prescale;
    tally_and_finish;
  end
endmodule
